// ==== include/srpc_defines.svh ====
// constants for the sync, range and power control block
`ifndef SRPC_DEFINES_SVH
`define SRPC_DEFINES_SVH
// register indices; byte address is index times four
`define SRPC_IDX_FILTER   6'h28
`define SRPC_IDX_SYNC     6'h2B
`define SRPC_IDX_RANGE    6'h2C
`define SRPC_IDX_POWER    6'h2D
`define SRPC_IDX_STATUS   6'h30
`define SRPC_IDX_CLEAR    6'h31
`define SRPC_IDX_ENABLE   6'h32
`define SRPC_IDX_SAMPLE   6'h33
// reset values
`define SRPC_RST_SYNC     8'h00
`define SRPC_RST_RANGE    8'h81
`define SRPC_RST_POWER    8'h01
`define SRPC_RST_FILTER   8'h00
// writable masks, reserved bits stay zero
`define SRPC_MASK_SYNC    8'h07
`define SRPC_MASK_RANGE   8'hC3
`define SRPC_MASK_POWER   8'h07
`define SRPC_MASK_FILTER  8'h7F
// field positions
`define SRPC_SYNC_EXTCLK  2
`define SRPC_RNG_HS       7
`define SRPC_RNG_POL      6
`define SRPC_PWR_FORCE    2
`define SRPC_PWR_TEMP     1
`define SRPC_PWR_STBY     0
// sync source codes
`define SRPC_SRC_INT      2'b00
`define SRPC_SRC_EXT      2'b01
`define SRPC_SRC_INTERP   2'b10
`define SRPC_SRC_RSVD     2'b11
// event bits
`define SRPC_EV_READY     0
`define SRPC_EV_OVERRUN   1
`define SRPC_EV_REFUSED   2
`define SRPC_EV_N         3
// timing; the oscillator divider counts system clocks, the delays and rate base count oscillator ticks
`define SRPC_OSC_DIV      8'h04
`define SRPC_ODR_BASE     20'h00100
`define SRPC_INTERP_MIN   14
`define SRPC_INTERP_STEP  819
`define SRPC_RATE_MAX     4'hA
`endif

// ==== include/srpc_pkg.sv ====
// types shared by the sync, range and power control block
package srpc_pkg;
  typedef logic [7:0]  srpc_byte_t;
  typedef logic [19:0] srpc_sample_t;
  typedef logic [1:0]  srpc_src_t;
  typedef enum logic [1:0] {
    SRPC_IDLE,
    SRPC_WAIT_TICK,
    SRPC_PENDING
  } srpc_state_e;
endpackage

// ==== include/srpc_smp_if.sv ====
// carrier between the register bank and the sample timing engine
interface srpc_smp_if;
  logic                 run;
  logic [1:0]           src;
  logic                 external_clock_select_sel;
  logic [3:0]           rate;
  logic                 external_clock_select;
  logic                 sync_source_select;
  logic [19:0]          accel;
  logic                 ready;
  logic [19:0]          data;
  logic                 overrun;
  modport ctrl (output run, src, external_clock_select_sel, rate, external_clock_select, sync_source_select,
                accel, input ready, data, overrun);
  modport eng  (input run, src, external_clock_select_sel, rate, external_clock_select, sync_source_select,
                accel, output ready, data, overrun);
endinterface

// ==== rtl/srpc_sampler.sv ====
// sample timing engine: oscillator, output rate and sync modes
`include "srpc_defines.svh"
module srpc_sampler
  import srpc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  srpc_smp_if.eng   s
);
  logic [7:0]   div_cnt;
  logic         osc_tick;
  logic         external_clock_select_q;
  logic         sync_q;
  logic         sync_edge;
  logic [19:0]  odr_cnt;
  logic [13:0]  dly_cnt;
  logic [13:0]  dly_target;
  srpc_sample_t held;
  srpc_state_e  state;

  function automatic logic [13:0] interp_delay(input logic [3:0] r);
    logic [3:0] rc;
    rc = (r > `SRPC_RATE_MAX) ? `SRPC_RATE_MAX : r;
    interp_delay = 14'(`SRPC_INTERP_MIN + `SRPC_INTERP_STEP * rc);
  endfunction

  assign sync_edge = s.sync_source_select & ~sync_q;
  assign osc_tick  = s.external_clock_select_sel ? (s.external_clock_select & ~external_clock_select_q)
                                   : (div_cnt == 8'h00);
  assign dly_target = interp_delay(s.rate);

  always_ff @(posedge clk_i) begin
    if (rst_i | ~s.run) begin
      div_cnt   <= `SRPC_OSC_DIV - 8'h01;
      // track the pins while idle so waking up sees no false edge
      external_clock_select_q <= s.external_clock_select;
      sync_q    <= s.sync_source_select;
    end else begin
      div_cnt   <= (div_cnt == 8'h00) ? `SRPC_OSC_DIV - 8'h01
                                      : div_cnt - 8'h01;
      external_clock_select_q <= s.external_clock_select;
      sync_q    <= s.sync_source_select;
    end
  end

  always_ff @(posedge clk_i) begin
    s.ready   <= 1'b0;
    s.overrun <= 1'b0;
    if (rst_i | ~s.run) begin
      state   <= SRPC_IDLE;
      odr_cnt <= 20'h00000;
      dly_cnt <= 14'h0000;
      held    <= '0;
      s.data  <= '0;
    end else begin
      case (s.src)
        `SRPC_SRC_INT: begin
          state <= SRPC_WAIT_TICK;
          if (osc_tick) begin
            if (odr_cnt >= (`SRPC_ODR_BASE << s.rate) - 20'h00001) begin
              odr_cnt <= 20'h00000;
              s.data  <= s.accel;
              s.ready <= 1'b1;
            end else begin
              odr_cnt <= odr_cnt + 20'h00001;
            end
          end
        end
        `SRPC_SRC_EXT: begin
          state <= SRPC_IDLE;
          if (sync_edge) begin
            s.data  <= s.accel;
            s.ready <= 1'b1;
          end
        end
        `SRPC_SRC_INTERP: begin
          // the value is caught at the sync and only released later
          if (sync_edge) begin
            held    <= s.accel;
            dly_cnt <= 14'h0000;
            state   <= SRPC_PENDING;
            s.overrun <= (state == SRPC_PENDING);
          end else if (state == SRPC_PENDING && osc_tick) begin
            if (dly_cnt >= dly_target - 14'h0001) begin
              s.data  <= held;
              s.ready <= 1'b1;
              state   <= SRPC_IDLE;
            end else begin
              dly_cnt <= dly_cnt + 14'h0001;
            end
          end
        end
        default: begin
          state <= SRPC_IDLE;
        end
      endcase
    end
  end
endmodule // srpc_sampler

// ==== rtl/sync_range_power_control.sv ====
// register bank for sync, range and power control with wishbone slave
`include "srpc_defines.svh"
module sync_range_power_control
  import srpc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  input  wire logic        external_clock_select_i,
  input  wire logic        sync_source_select_i,
  input  wire logic [19:0] accel_i,
  output logic             sample_ready_pin_o,
  output logic             irq_line_a_o,
  output logic             irq_line_b_o,
  output logic             irq_o,
  output logic             ext_clock_sel_o,
  output logic             bus_high_speed_o,
  output logic      [1:0]  range_o,
  output logic             accel_active_o,
  output logic             temp_active_o,
  output logic             digital_reset_o
);
  srpc_byte_t                 sync_control;
  srpc_byte_t                 bus_irq_range_control;
  srpc_byte_t                 power_control;
  srpc_byte_t                 filter_control;
  logic [`SRPC_EV_N-1:0]      irq_status;
  logic [`SRPC_EV_N-1:0]      irq_enable;
  logic [`SRPC_EV_N-1:0]      event_set;
  logic [`SRPC_EV_N-1:0]      clear_req;
  srpc_sample_t               sample_data;
  logic                       standby_q;
  logic                       entering_standby;
  logic                       wr_req;
  logic                       rd_req;
  logic [5:0]                 idx;
  srpc_byte_t                 wbyte;
  logic                       cfg_write;
  logic                       refused;
  logic [31:0]                next_dat;
  logic                       level_a;
  logic                       level_b;
  logic                       wr_sync;
  logic                       wr_range;
  logic                       wr_power;
  logic                       wr_filter;
  logic                       wr_enable;
  logic                       wr_clear;

  srpc_smp_if smp ();

  function automatic logic hit(input logic [7:0] a, input logic [5:0] i);
    hit = (a[7:2] == i);
  endfunction

  function automatic logic [31:0] widen(input srpc_byte_t b);
    widen = {24'h000000, b};
  endfunction

  function automatic logic [31:0] widen_ev(input logic [`SRPC_EV_N-1:0] e);
    widen_ev = {29'h00000000, e};
  endfunction

  // the lines idle at the inverse of their active level
  function automatic logic drive_line(input logic lvl, input logic pol);
    drive_line = lvl ~^ pol;
  endfunction

  // ------------------------------------------------------------ bus
  assign idx    = adr_i[7:2];
  assign wbyte  = dat_i[7:0];
  assign wr_req = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
  assign rd_req = cyc_i & stb_i & ~we_i & ~ack_o;

  // one strobe per register keeps the address decode in one place
  assign wr_sync   = wr_req & hit(adr_i, `SRPC_IDX_SYNC);
  assign wr_range  = wr_req & hit(adr_i, `SRPC_IDX_RANGE);
  assign wr_power  = wr_req & hit(adr_i, `SRPC_IDX_POWER);
  assign wr_filter = wr_req & hit(adr_i, `SRPC_IDX_FILTER);
  assign wr_enable = wr_req & hit(adr_i, `SRPC_IDX_ENABLE);
  assign wr_clear  = wr_req & hit(adr_i, `SRPC_IDX_CLEAR);

  // sync and range configuration writes are only taken in
  // standby; a refused write is still acked so the bus never hangs
  assign cfg_write = wr_sync | wr_range;
  assign refused   = cfg_write & ~power_control[`SRPC_PWR_STBY];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
    end
  end

  always_comb begin
    next_dat = 32'h00000000;
    case (idx)
      `SRPC_IDX_FILTER: next_dat = widen(filter_control);
      `SRPC_IDX_SYNC:   next_dat = widen(sync_control);
      `SRPC_IDX_RANGE:  next_dat = widen(bus_irq_range_control);
      `SRPC_IDX_POWER:  next_dat = widen(power_control);
      `SRPC_IDX_STATUS: next_dat = widen_ev(irq_status);
      `SRPC_IDX_ENABLE: next_dat = widen_ev(irq_enable);
      `SRPC_IDX_SAMPLE: next_dat = {12'h000, sample_data};
      default:          next_dat = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (rd_req) begin
      dat_o <= next_dat;
    end
  end

  // ------------------------------------------------------ registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_control <= `SRPC_RST_SYNC;
    end else if (wr_sync & ~refused) begin
      // the reserved source code is never stored
      if (wbyte[1:0] != `SRPC_SRC_RSVD) begin
        sync_control <= wbyte & `SRPC_MASK_SYNC;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_irq_range_control <= `SRPC_RST_RANGE;
    end else if (wr_range & ~refused) begin
      bus_irq_range_control <= wbyte & `SRPC_MASK_RANGE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_control <= `SRPC_RST_POWER;
    end else if (wr_power) begin
      power_control <= wbyte & `SRPC_MASK_POWER;
    end
  end

  // filter stays writable while measuring
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filter_control <= `SRPC_RST_FILTER;
    end else if (wr_filter) begin
      filter_control <= wbyte & `SRPC_MASK_FILTER;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_enable <= '0;
    end else if (wr_enable) begin
      irq_enable <= wbyte[`SRPC_EV_N-1:0];
    end
  end

  // ------------------------------------------------- standby control
  assign entering_standby = power_control[`SRPC_PWR_STBY] & ~standby_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      standby_q <= 1'b1;
    end else begin
      standby_q <= power_control[`SRPC_PWR_STBY];
    end
  end

  // one-cycle pulse that clears fifo pointers and other digital state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      digital_reset_o <= 1'b1;
    end else begin
      digital_reset_o <= entering_standby;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accel_active_o <= 1'b0;
    end else begin
      accel_active_o <= ~power_control[`SRPC_PWR_STBY];
    end
  end

  // standby overrides the temperature enable whatever that bit holds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      temp_active_o <= 1'b0;
    end else begin
      temp_active_o <= ~power_control[`SRPC_PWR_TEMP]
                     & ~power_control[`SRPC_PWR_STBY];
    end
  end

  // -------------------------------------------------- config pins
  // pins follow their fields one cycle after the write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_clock_sel_o <= 1'b0;
    end else begin
      ext_clock_sel_o <= sync_control[`SRPC_SYNC_EXTCLK];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_high_speed_o <= 1'b1;
    end else begin
      bus_high_speed_o <= bus_irq_range_control[`SRPC_RNG_HS];
    end
  end

  // range 00 is not defined and is passed through unchanged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      range_o <= 2'(`SRPC_RST_RANGE);
    end else begin
      range_o <= bus_irq_range_control[1:0];
    end
  end

  // ------------------------------------------------- sample engine
  // the engine is held cleared for the whole standby period
  assign smp.run         = ~power_control[`SRPC_PWR_STBY];
  assign smp.src         = sync_control[1:0];
  assign smp.external_clock_select_sel = sync_control[`SRPC_SYNC_EXTCLK];
  assign smp.rate        = filter_control[3:0];
  assign smp.external_clock_select     = external_clock_select_i;
  assign smp.sync_source_select    = sync_source_select_i;
  assign smp.accel       = accel_i;

  srpc_sampler u_sampler (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .s     (smp.eng)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i | entering_standby) begin
      sample_data <= '0;
    end else if (smp.ready) begin
      sample_data <= smp.data;
    end
  end

  // forced low only masks the pin; the status event still fires
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_ready_pin_o <= 1'b0;
    end else begin
      sample_ready_pin_o <= smp.ready
                          & ~power_control[`SRPC_PWR_FORCE];
    end
  end

  // ---------------------------------------------------- interrupts
  assign event_set[`SRPC_EV_READY]   = smp.ready;
  assign event_set[`SRPC_EV_OVERRUN] = smp.overrun;
  assign event_set[`SRPC_EV_REFUSED] = refused;
  // clear is write-one: zeros written leave their bits alone
  always_comb begin
    clear_req = '0;
    if (wr_clear) begin
      clear_req = wbyte[`SRPC_EV_N-1:0];
    end
  end

  // a new event in the clearing cycle wins over the clear
  genvar g;
  generate
    for (g = 0; g < `SRPC_EV_N; g = g + 1) begin : g_status
      always_ff @(posedge clk_i) begin
        if (rst_i | entering_standby) begin
          irq_status[g] <= 1'b0;
        end else if (event_set[g]) begin
          irq_status[g] <= 1'b1;
        end else if (clear_req[g]) begin
          irq_status[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign level_a = irq_status[`SRPC_EV_READY] & irq_enable[`SRPC_EV_READY];
  assign level_b = |(irq_status[`SRPC_EV_REFUSED:`SRPC_EV_OVERRUN]
                   & irq_enable[`SRPC_EV_REFUSED:`SRPC_EV_OVERRUN]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_enable);
    end
  end

  // polarity zero inverts so an idle line sits high, as after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_line_a_o <= 1'b1;
    end else begin
      irq_line_a_o <= drive_line(level_a,
                                 bus_irq_range_control[`SRPC_RNG_POL]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_line_b_o <= 1'b1;
    end else begin
      irq_line_b_o <= drive_line(level_b,
                                 bus_irq_range_control[`SRPC_RNG_POL]);
    end
  end
endmodule // sync_range_power_control

// ==== verification/srpc_checker_props.sv ====
// port assertions for the sync, range and power control block
module srpc_checker (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  input wire logic       sample_ready_pin_o,
  input wire logic       irq_line_a_o,
  input wire logic       irq_line_b_o,
  input wire logic       irq_o,
  input wire logic       bus_high_speed_o,
  input wire logic [1:0] range_o,
  input wire logic       accel_active_o,
  input wire logic       temp_active_o,
  input wire logic       digital_reset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s; cyc_i && stb_i && !ack_o; endsequence
  sequence ans_s; ack_o ##1 !ack_o; endsequence
  bus_answer_a: assert property (req_s |=> ans_s)
    else $error("bus request not answered once");
  bus_quiet_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("answer without request");
  // reset itself is the cause here, so it must not disable the check
  reset_vals_a: assert property (disable iff (1'b0)
    rst_i |=> bus_high_speed_o && range_o == 2'b01 && !accel_active_o
      && irq_line_a_o && irq_line_b_o && !irq_o)
    else $error("wrong value after reset");
  temp_gate_a: assert property (temp_active_o |-> accel_active_o)
    else $error("temperature runs in standby");
  pin_pulse_a: assert property (
    sample_ready_pin_o |=> !sample_ready_pin_o)
    else $error("ready pin longer than one cycle");
  pin_halt_a: assert property (
    sample_ready_pin_o |-> $past(accel_active_o))
    else $error("ready pin while in standby");
  line_pair_a: assert property (
    !irq_o |-> irq_line_a_o == irq_line_b_o)
    else $error("idle irq lines differ");
  clear_pulse_a: assert property (
    digital_reset_o |=> !digital_reset_o)
    else $error("digital reset longer than one cycle");
endmodule // srpc_checker
bind sync_range_power_control srpc_checker i_srpc_checker (
  .clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .sample_ready_pin_o,
  .irq_line_a_o, .irq_line_b_o, .irq_o, .bus_high_speed_o, .range_o,
  .accel_active_o, .temp_active_o, .digital_reset_o);

// ==== verification/srpc_sensor_model.sv ====
// sensor front end model: free oscillator, sync pulses and samples
module srpc_sensor_model (
  input  wire logic        clk_i,
  input  wire logic        fire_i,
  input  wire logic [19:0] value_i,
  output logic             external_clock_select_o = 1'b0,
  output logic             sync_source_select_o = 1'b0,
  output logic      [19:0] accel_o = 20'h00000
);
  timeunit 1ns;
  timeprecision 1ps;
  int phase = 0;
  int hold = 0;
  // oscillator runs free, one period is six system clocks
  always @(posedge clk_i) begin
    phase <= (phase == 2) ? 0 : phase + 1;
    if (phase == 2)
      external_clock_select_o <= ~external_clock_select_o;
  end
  // sample held around the sync edge, then it changes every cycle so a
  // late capture shows up as wrong data
  always @(posedge clk_i) begin
    if (fire_i) begin
      accel_o <= value_i;
      hold <= 4;
    end else if (hold != 0)
      hold <= hold - 1;
    else
      accel_o <= ~accel_o;
    sync_source_select_o <= fire_i || hold > 1;
  end
endmodule // srpc_sensor_model

// ==== verification/tb_top.sv ====
// self-checking bench for the sync, range and power control block
`include "srpc_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, ack, pin, irq_a, irq_b, irq, external_clock_select, sync_source_select;
  logic        ext_sel, hs, acc_on, temp_on, dig_rst;
  logic        rst = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0, fire = 1'b0;
  logic [7:0]  adr = 8'h00, d;
  logic [31:0] dat_w = 32'h0, dat_r;
  logic [3:0]  sel = 4'hF;
  logic [1:0]  rng;
  logic [19:0] accel, v = 20'h0;
  logic [31:0] exq[$];
  string       nmq[$];
  int          miscompares = 0, compares = 0, resets = 0, n, p;
  sync_range_power_control i_sync_range_power_control (
    .clk_i(clk), .rst_i(rst), .adr_i(adr), .dat_i(dat_w), .dat_o(dat_r),
    .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
    .external_clock_select_i(external_clock_select), .sync_source_select_i(sync_source_select), .accel_i(accel),
    .sample_ready_pin_o(pin), .irq_line_a_o(irq_a), .irq_line_b_o(irq_b),
    .irq_o(irq), .ext_clock_sel_o(ext_sel), .bus_high_speed_o(hs),
    .range_o(rng), .accel_active_o(acc_on), .temp_active_o(temp_on),
    .digital_reset_o(dig_rst));
  srpc_sensor_model i_srpc_sensor_model (
    .clk_i(clk), .fire_i(fire), .value_i(v), .external_clock_select_o(external_clock_select),
    .sync_source_select_o(sync_source_select), .accel_o(accel));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one classic cycle; only the watchdog ends the wait for a dead slave
  task automatic bus(logic w, logic [5:0] idx, logic [7:0] wd);
    int k;
    k = 0;
    {adr, dat_w, we, cyc, stb} <= {idx, 2'b00, 24'h0, wd, w, 2'b11};
    @(posedge clk);
    while (ack !== 1'b1) begin
      k++;
      @(posedge clk);
    end
    check("bus wait", k, 1);
    {cyc, stb} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic wr(logic [5:0] idx, logic [7:0] wd);
    bus(1'b1, idx, wd);
  endtask
  task automatic rd(logic [5:0] idx, logic [31:0] e, string name);
    exq.push_back(e);
    nmq.push_back(name);
    bus(1'b0, idx, 8'h00);
  endtask
  // one sync event from the model, then count cycles until the pin
  task automatic pulse(int lim);
    n = 0;
    v <= 20'($urandom);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    while (pin !== 1'b1 && n < lim) begin
      n++;
      @(posedge clk);
    end
  endtask
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && exq.size() > 0)
      check(nmq.pop_front(), dat_r, exq.pop_front());
    if (dig_rst === 1'b1 && rst === 1'b0)
      resets++;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end
  initial begin
    void'($urandom(39));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`SRPC_IDX_SYNC, 32'h00, "sync reset");
    rd(`SRPC_IDX_RANGE, 32'h81, "range reset");
    rd(`SRPC_IDX_POWER, 32'h01, "power reset");
    check("bus mode", hs, 1);
    check("temp path", temp_on, 0);
    check("irq idle", irq_a, 1);
    $display("test reset done");
    wr(`SRPC_IDX_SYNC, 8'hFE);
    rd(`SRPC_IDX_SYNC, 32'h06, "sync mask");
    check("ext clock", ext_sel, 1);
    wr(`SRPC_IDX_SYNC, 8'hFB);
    rd(`SRPC_IDX_SYNC, 32'h06, "sync reserved code");
    for (int c = 1; c < 4; c++) begin
      d = (8'($urandom) & 8'hFC) | 8'(c);
      wr(`SRPC_IDX_RANGE, d);
      rd(`SRPC_IDX_RANGE, {24'h0, d & 8'hC3}, "range value");
      check("range field", rng, c);
      check("bus mode", hs, d[7]);
      check("idle level", {irq_a, irq_b}, {2{~d[6]}});
    end
    wr(6'h3F, 8'hA5);
    rd(6'h3F, 32'h0, "unmapped");
    $display("test fields done");
    wr(`SRPC_IDX_POWER, 8'hFA);
    rd(`SRPC_IDX_POWER, 32'h02, "power mask");
    check("accel path", acc_on, 1);
    check("temp path", temp_on, 0);
    wr(`SRPC_IDX_RANGE, 8'h42);
    rd(`SRPC_IDX_RANGE, {24'h0, d & 8'hC3}, "range measuring");
    rd(`SRPC_IDX_STATUS, 32'h04, "refused event");
    wr(`SRPC_IDX_FILTER, 8'h35);
    rd(`SRPC_IDX_FILTER, 32'h35, "filter measuring");
    wr(`SRPC_IDX_POWER, 8'h00);
    check("temp path", temp_on, 1);
    p = resets;
    wr(`SRPC_IDX_POWER, 8'h01);
    @(posedge clk);
    check("digital reset", resets, p + 1);
    check("standby temp", temp_on, 0);
    rd(`SRPC_IDX_STATUS, 32'h00, "status after standby");
    $display("test power done");
    wr(`SRPC_IDX_SYNC, 8'h01);
    wr(`SRPC_IDX_RANGE, 8'hC1);
    wr(`SRPC_IDX_ENABLE, 8'h07);
    wr(`SRPC_IDX_POWER, 8'h00);
    pulse(12);
    check("sync to ready", n, 3);
    repeat (2) @(posedge clk);
    check("irq level", {irq, irq_a, irq_b}, 3'b110);
    rd(`SRPC_IDX_SAMPLE, {12'h0, v}, "direct sample");
    wr(`SRPC_IDX_CLEAR, 8'h07);
    rd(`SRPC_IDX_STATUS, 32'h00, "status cleared");
    wr(`SRPC_IDX_POWER, 8'h04);
    pulse(20);
    check("forced pin", n, 20);
    rd(`SRPC_IDX_STATUS, 32'h01, "ready without pin");
    wr(`SRPC_IDX_RANGE, 8'hC2);
    check("irq b line", irq_b, 1);
    rd(`SRPC_IDX_STATUS, 32'h05, "refused measuring");
    $display("test direct sync done");
    // internal tick is four clocks, the model's oscillator six
    for (int e = 0; e < 2; e++) begin
      p = e ? 6 : 4;
      wr(`SRPC_IDX_POWER, 8'h01);
      wr(`SRPC_IDX_SYNC, {5'h0, 1'(e), 2'b10});
      wr(`SRPC_IDX_FILTER, 8'h00);
      wr(`SRPC_IDX_POWER, 8'h00);
      pulse(200);
      check("interp delay",
            n >= 13 * p + 4 && n <= 14 * p + 3, 1);
      rd(`SRPC_IDX_SAMPLE, {12'h0, v}, "interp sample");
    end
    $display("test interpolation done");
    // internal sync at rate 0: 256 ticks of four clocks between pulses
    wr(`SRPC_IDX_POWER, 8'h01);
    wr(`SRPC_IDX_SYNC, 8'h00);
    wr(`SRPC_IDX_POWER, 8'h00);
    pulse(2000);
    pulse(2000);
    check("internal period", n, 1023);
    $display("test internal sync done");
    conclude();
  end
endmodule // tb_top
